// ==== ssm_regs.vh ====
// constants of the system manager serial slave engine
`ifndef SSM_REGS_VH
`define SSM_REGS_VH

// slave address layout
`define SSM_DEV_ID 4'ha
`define SSM_SEL_LOW 2'h0
`define SSM_SEL_HIGH 2'h1
`define SSM_SEL_SCL 2'h2
`define SSM_SEL_SDA 2'h3

// command codes
`define SSM_CMD_BLK_WR 8'h94
`define SSM_CMD_BLK_RD 8'h95
`define SSM_CMD_REBOOT 8'h96
`define SSM_CMD_FAULT 8'h97
`define SSM_CMD_EXT_ON 8'h98
`define SSM_CMD_EXT_OFF 8'h99
`define SSM_CMD_NVM_ON 8'h9a
`define SSM_CMD_NVM_OFF 8'h9b

// register pages
`define SSM_PAGE_DEF 2'h0
`define SSM_PAGE_EXT 2'h1
`define SSM_PAGE_NVM 2'h2

// address limits
`define SSM_CFG_LAST 8'h7d
`define SSM_EXT_LAST 8'h3f
`define SSM_NVM_LAST 8'hff
`define SSM_BOOT_FIRST 8'h0f
`define SSM_BOOT_LAST 8'h7d

// block transfers
`define SSM_BLK_MAX 5'h10
`define SSM_BLK_MIN 5'h01
`define SSM_BLK_LAST 5'h0f

`endif

// ==== ssm_bus_sense.v ====
// pin synchronisers, bus condition detection and address-select decoding
`timescale 1ns/1ps
`include "ssm_regs.vh"

module ssm_bus_sense (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // bus pins
  input wire scl_i,
  input wire sda_i,
  input wire bus_address_select_pin,
  // synchronised view
  output wire sda_s,
  output wire scl_rise,
  output wire scl_fall,
  output wire start_det,
  output wire stop_det,
  output wire [1:0] sel_code
);

  reg scl_m_q, scl_s_q, scl_p_q;
  reg sda_m_q, sda_s_q, sda_p_q;
  reg pin_m_q, pin_s_q;
  reg ne_scl_q, ne_sda_q, lo_q;

  // two-stage synchronisers, plus one history stage for SCL and SDA only
  always @(posedge clk) begin
    if (!rst_n) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
      pin_m_q <= 1'b1; // idle bus level, no false low
      pin_s_q <= 1'b1; // idle bus level, no false low
    end else begin
      scl_m_q <= scl_i;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
      pin_m_q <= bus_address_select_pin;
      pin_s_q <= pin_m_q;
    end
  end

  // sticky observations of the select pin against both bus lines
  always @(posedge clk) begin
    if (!rst_n) begin
      ne_scl_q <= 1'b0;
      ne_sda_q <= 1'b0;
      lo_q <= 1'b0;
    end else begin
      if (pin_s_q != scl_s_q)
        ne_scl_q <= 1'b1;
      if (pin_s_q != sda_s_q)
        ne_sda_q <= 1'b1;
      if (!pin_s_q && scl_s_q && sda_s_q)
        lo_q <= 1'b1;
    end
  end

  assign sda_s = sda_s_q;
  assign scl_rise = scl_s_q & ~scl_p_q;
  assign scl_fall = ~scl_s_q & scl_p_q;
  assign start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign stop_det = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

  assign sel_code = lo_q ? `SSM_SEL_LOW :
                    !ne_scl_q ? `SSM_SEL_SCL :
                    !ne_sda_q ? `SSM_SEL_SDA : `SSM_SEL_HIGH;

endmodule

// ==== ssm_addr_check.v ====
// legal memory address check for the selected page
`timescale 1ns/1ps
`include "ssm_regs.vh"

module ssm_addr_check (
  // page and address
  input wire [1:0] page,
  input wire [7:0] addr,
  // result
  output reg valid
);

  // every address is legal in the nonvolatile page
  always @* begin
    if (page == `SSM_PAGE_NVM)
      valid = 1'b1;
    else if (page == `SSM_PAGE_EXT)
      valid = (addr <= `SSM_EXT_LAST);
    else
      valid = (addr <= `SSM_CFG_LAST);
  end

endmodule

// ==== ssm_i2c_slave.v ====
// serial slave protocol engine of the supply-monitoring system manager
//
// Overview of operation
// - acknowledge received address and data bytes by pulling SDA low in bit nine
// - release SDA in bit nine of transmitted bytes; master acknowledges
// - refuse command byte during reboot, memory write, or for an illegal address
// - answer address 1010 plus select-pin code; address bit 1 ignored
// - send byte loads the pointer if allowed; block codes acknowledged unless busy
// - stop before the command acknowledge leaves the pointer unchanged
// - receive byte returns data at pointer, then pointer advances by one
// - write byte stores data at a valid address of the current page
// - read byte: invalid address is refused and the pointer kept
// - reboot code requests the same action as power-on reset
// - fault-store code requests fault data be stored in nonvolatile memory
// - one code selects the extended page, another returns to default page
// - nonvolatile page code holds until a return-to-default, extended-page or reboot code
// - block write: count of 1 to 16, data from pointer onward
// - block write pointer saturates at FFh or 7Dh; last byte wins
// - block write code refused when busy, pointer then unchanged
// - block read gives at most 16 bytes; master may end early
// - block read pointer saturates at FFh
// - block read code acknowledged unless busy, then repeated start read
// - block read sends a byte count of 16 before the data bytes
`timescale 1ns/1ps
`include "ssm_regs.vh"
module ssm_i2c_slave (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // serial bus pins
  input wire scl_i,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe,
  input wire bus_address_select_pin,
  // device status
  input wire reboot_busy,
  input wire nvm_busy,
  // memory access
  output reg mem_rd_req,
  output reg mem_wr_req,
  output reg [7:0] mem_addr,
  output reg [7:0] mem_wdata,
  output reg [1:0] mem_page,
  input wire [7:0] mem_rdata,
  // device commands
  output reg reboot_req,
  output reg fault_store_req
);

  // link states
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_RX = 3'h1;
  localparam [2:0] S_ACK = 3'h2;
  localparam [2:0] S_ACK2 = 3'h3;
  localparam [2:0] S_TX = 3'h4;
  localparam [2:0] S_MACK = 3'h5;
  localparam [2:0] S_LOAD = 3'h6;
  // meaning of the byte being received
  localparam [2:0] B_ADDR = 3'h0;
  localparam [2:0] B_CMD = 3'h1;
  localparam [2:0] B_CNT = 3'h2;
  localparam [2:0] B_DATA = 3'h3;
  localparam [2:0] B_IGN = 3'h4;
  // internal nets and state
  wire sda_s, scl_rise, scl_fall, start_det, stop_det;
  wire [1:0] sel_code;
  wire addr_ok, busy;
  wire [7:0] rx_byte, tx_byte, next_ptr, wr_lim;
  reg [2:0] st_q, byte_q;
  reg [3:0] bit_q;
  reg [7:0] sh_q, ptr_q, pend_q;
  reg [1:0] page_q;
  reg [4:0] cnt_q;
  // pointer load waits for the acknowledge
  reg ack_q, rw_q, blk_wr_q, blk_rd_q, first_q, pend_v_q, ptr_ld_q;
  // saturating pointer step
  function [7:0] sat_inc;
    input [7:0] p;
    input [7:0] lim;
    begin
      if (p >= lim)
        sat_inc = lim;
      else
        sat_inc = p + 8'h01;
    end
  endfunction
  ssm_bus_sense u_sense (
    .clk(clk),
    .rst_n(rst_n),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .bus_address_select_pin(bus_address_select_pin),
    .sda_s(sda_s),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_det(start_det),
    .stop_det(stop_det),
    .sel_code(sel_code)
  );
  ssm_addr_check u_check (
    .page(page_q),
    .addr(rx_byte),
    .valid(addr_ok)
  );
  // byte being completed and byte to send
  assign rx_byte = {sh_q[6:0], sda_s};
  assign busy = reboot_busy | nvm_busy;
  assign tx_byte = first_q ? {3'h0, `SSM_BLK_MAX} : mem_rdata;
  assign wr_lim = (page_q == `SSM_PAGE_NVM) ? `SSM_NVM_LAST : `SSM_CFG_LAST;
  assign next_ptr = blk_rd_q ? sat_inc(ptr_q, `SSM_NVM_LAST) : ptr_q + 8'h01;
  // protocol engine
  always @(posedge clk) begin
    if (!rst_n) begin
      st_q <= S_IDLE;
      byte_q <= B_ADDR;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      ack_q <= 1'b0;
      rw_q <= 1'b0;
      ptr_q <= 8'h00;
      page_q <= `SSM_PAGE_DEF;
      blk_wr_q <= 1'b0;
      blk_rd_q <= 1'b0;
      first_q <= 1'b0;
      cnt_q <= 5'h00;
      pend_q <= 8'h00;
      pend_v_q <= 1'b0;
      ptr_ld_q <= 1'b0;
      sda_o <= 1'b0;
      sda_oe <= 1'b0;
      mem_rd_req <= 1'b0;
      mem_wr_req <= 1'b0;
      mem_addr <= 8'h00;
      mem_wdata <= 8'h00;
      mem_page <= `SSM_PAGE_DEF;
      reboot_req <= 1'b0;
      fault_store_req <= 1'b0;
    end else begin
      mem_rd_req <= 1'b0;
      mem_wr_req <= 1'b0;
      reboot_req <= 1'b0;
      fault_store_req <= 1'b0;
      mem_page <= page_q;
      if (stop_det) begin
        st_q <= S_IDLE;
        sda_oe <= 1'b0;
        blk_wr_q <= 1'b0;
        blk_rd_q <= 1'b0;
        pend_v_q <= 1'b0;
        if (pend_v_q) begin
          if (pend_q == `SSM_CMD_REBOOT) begin
            reboot_req <= 1'b1;
            page_q <= `SSM_PAGE_DEF;
          end
          if (pend_q == `SSM_CMD_FAULT)
            fault_store_req <= 1'b1;
          if (pend_q == `SSM_CMD_EXT_ON)
            page_q <= `SSM_PAGE_EXT;
          if (pend_q == `SSM_CMD_NVM_ON)
            page_q <= `SSM_PAGE_NVM;
          if (pend_q == `SSM_CMD_EXT_OFF || pend_q == `SSM_CMD_NVM_OFF)
            page_q <= `SSM_PAGE_DEF;
        end
      end else if (start_det) begin
        // start or repeated start: expect an address
        st_q <= S_RX;
        byte_q <= B_ADDR;
        bit_q <= 4'h0;
        sda_oe <= 1'b0;
        pend_v_q <= 1'b0;
      end else begin
        case (st_q)
          S_RX: begin
            if (scl_rise) begin
              sh_q <= rx_byte;
              bit_q <= bit_q + 4'h1;
              if (bit_q == 4'h7) begin
                st_q <= S_ACK;
                ack_q <= 1'b0;
                ptr_ld_q <= 1'b0;
                if (byte_q == B_ADDR) begin
                  if (rx_byte[7:4] == `SSM_DEV_ID && rx_byte[3:2] == sel_code) begin
                    ack_q <= 1'b1;
                    rw_q <= rx_byte[0];
                    if (rx_byte[0]) begin
                      mem_rd_req <= 1'b1;
                      mem_addr <= ptr_q;
                      first_q <= blk_rd_q;
                      cnt_q <= 5'h00;
                    end else begin
                      byte_q <= B_CMD;
                      blk_rd_q <= 1'b0;
                      blk_wr_q <= 1'b0;
                    end
                  end
                end else if (byte_q == B_CMD) begin
                  if (rx_byte >= `SSM_CMD_BLK_WR && rx_byte <= `SSM_CMD_NVM_OFF) begin
                    // refuse commands while busy, pointer kept
                    ack_q <= !busy;
                    byte_q <= B_IGN;
                    if (!busy) begin
                      if (rx_byte == `SSM_CMD_BLK_WR) begin
                        blk_wr_q <= 1'b1;
                        byte_q <= B_CNT;
                      end else if (rx_byte == `SSM_CMD_BLK_RD) begin
                        blk_rd_q <= 1'b1;
                      end else begin
                        pend_q <= rx_byte;
                        pend_v_q <= 1'b1;
                      end
                    end
                  end else if (addr_ok && !busy) begin
                    // pointer load held until the acknowledge
                    ack_q <= 1'b1;
                    ptr_ld_q <= 1'b1;
                    byte_q <= B_DATA;
                  end else begin
                    byte_q <= B_IGN;
                  end
                end else if (byte_q == B_CNT) begin
                  if (rx_byte <= {3'h0, `SSM_BLK_MAX} && rx_byte != 8'h00) begin
                    ack_q <= 1'b1;
                    cnt_q <= rx_byte[4:0];
                    byte_q <= B_DATA;
                  end else begin
                    byte_q <= B_IGN;
                  end
                end else if (byte_q == B_DATA) begin
                  ack_q <= 1'b1;
                  mem_wr_req <= 1'b1;
                  mem_addr <= ptr_q;
                  mem_wdata <= rx_byte;
                  if (blk_wr_q) begin
                    ptr_q <= sat_inc(ptr_q, wr_lim);
                    cnt_q <= cnt_q - 5'h01;
                    if (cnt_q == `SSM_BLK_MIN)
                      byte_q <= B_IGN;
                  end else begin
                    byte_q <= B_IGN;
                  end
                end
              end
            end
          end
          S_ACK: begin
            // pull SDA low for bit nine
            if (scl_fall) begin
              sda_oe <= ack_q;
              st_q <= S_ACK2;
              // a stop before this point leaves the pointer alone
              if (ptr_ld_q)
                ptr_q <= sh_q;
            end
          end
          S_ACK2: begin
            if (scl_fall) begin
              bit_q <= 4'h0;
              sda_oe <= 1'b0;
              if (!ack_q)
                st_q <= S_IDLE;
              else if (rw_q) begin
                sh_q <= tx_byte;
                sda_oe <= ~tx_byte[7];
                bit_q <= 4'h1;
                st_q <= S_TX;
              end else
                st_q <= S_RX;
            end
          end
          S_TX: begin
            if (scl_fall) begin
              if (bit_q == 4'h8) begin
                // release SDA for the master acknowledge
                sda_oe <= 1'b0;
                st_q <= S_MACK;
              end else begin
                sda_oe <= ~sh_q[6];
                sh_q <= {sh_q[6:0], 1'b0};
                bit_q <= bit_q + 4'h1;
              end
            end
          end
          S_MACK: begin
            if (scl_rise) begin
              if (first_q) begin
                first_q <= 1'b0;
                mem_rd_req <= 1'b1;
                mem_addr <= ptr_q;
                st_q <= sda_s ? S_IDLE : S_LOAD;
              end else begin
                ptr_q <= next_ptr;
                cnt_q <= cnt_q + 5'h01;
                // stop driving on nack or after 16 block read data bytes
                if (sda_s || (blk_rd_q && cnt_q == `SSM_BLK_LAST))
                  st_q <= S_IDLE;
                else begin
                  mem_rd_req <= 1'b1;
                  mem_addr <= next_ptr;
                  st_q <= S_LOAD;
                end
              end
            end
          end
          S_LOAD: begin
            if (scl_fall) begin
              sh_q <= tx_byte;
              sda_oe <= ~tx_byte[7];
              bit_q <= 4'h1;
              st_q <= S_TX;
            end
          end
          default: st_q <= S_IDLE;
        endcase
      end
    end
  end
endmodule

// ==== ssm_checker.sv ====
// port checker for the serial slave engine
`timescale 1ns/1ps
module ssm_checker (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // serial bus
  input wire scl_i,
  input wire sda_i,
  input wire sda_o,
  input wire sda_oe,
  // memory and commands
  input wire mem_rd_req,
  input wire mem_wr_req,
  input wire [7:0] mem_addr,
  input wire [1:0] mem_page,
  input wire reboot_req,
  input wire fault_store_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // quiet outputs after reset
  rst_quiet_a: assert property ($rose(rst_n) |-> !sda_oe && mem_page == 2'h0)
    else $error("outputs not quiet after reset");
  open_drain_a: assert property (!sda_o)
    else $error("data pin driven high");
  sda_edge_a: assert property ((sda_oe != $past(sda_oe)) |-> !scl_i)
    else $error("data changed while clock high");
  rd_pulse_a: assert property (mem_rd_req |=> !mem_rd_req)
    else $error("read request longer than one cycle");
  wr_pulse_a: assert property (mem_wr_req |=> !mem_wr_req && $stable(mem_addr))
    else $error("write request malformed");
  wr_legal_a: assert property (mem_wr_req |-> mem_page == 2'h2 ||
    (mem_page == 2'h1 ? mem_addr <= 8'h3f : mem_addr <= 8'h7d))
    else $error("write to illegal address");
  page_stop_a: assert property ((mem_page != $past(mem_page)) |-> scl_i && sda_i)
    else $error("page changed outside stop");
  cmd_stop_a: assert property ((reboot_req || fault_store_req) |-> scl_i && sda_i
    ##1 !reboot_req && !fault_store_req)
    else $error("command pulse malformed");
  page_code_a: assert property (mem_page != 2'h3)
    else $error("unknown page code");
  oe_bound_a: assert property ($rose(sda_oe) |-> ##[1:200] !sda_oe)
    else $error("data line held too long");
  // main scenarios
  cover property (mem_wr_req);
  cover property (reboot_req);
  cover property (mem_page == 2'h2);
endmodule

bind ssm_i2c_slave ssm_checker chk_i (.clk(clk), .rst_n(rst_n), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .mem_rd_req(mem_rd_req), .mem_wr_req(mem_wr_req),
  .mem_addr(mem_addr), .mem_page(mem_page), .reboot_req(reboot_req),
  .fault_store_req(fault_store_req));

// ==== ssm_master_model.sv ====
// bus master model driving clock and wired data line
`timescale 1ns/1ps
module ssm_master_model (
  // clock
  input wire clk,
  // device pull-down
  input wire sda_oe,
  // bus lines
  output reg scl,
  output wire sda
);
  reg sda_q = 1'b1;
  // wired data line with pull-up
  assign sda = sda_q & ~sda_oe;
  initial scl = 1'b1;
  task half;
    begin
      repeat (8) @(posedge clk);
    end
  endtask
  // one bit: low phase, data set, high phase, sample
  task bit_x(input v, output r);
    begin
      half;
      sda_q <= v;
      half;
      scl <= 1'b1;
      half;
      r = sda;
      scl <= 1'b0;
    end
  endtask
  task start;
    begin
      sda_q <= 1'b1;
      half;
      scl <= 1'b1;
      half;
      sda_q <= 1'b0;
      half;
      scl <= 1'b0;
    end
  endtask
  task stop;
    begin
      half;
      sda_q <= 1'b0;
      half;
      scl <= 1'b1;
      half;
      sda_q <= 1'b1;
      half;
    end
  endtask
  task wbyte(input [7:0] b, output ack);
    integer i;
    reg r;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bit_x(b[i], r);
      end
      bit_x(1'b1, r);
      ack = ~r;
    end
  endtask
  task rbyte(input nak, output [7:0] b);
    integer i;
    reg r;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bit_x(1'b1, r);
        b[i] = r;
      end
      bit_x(nak, r);
    end
  endtask
endmodule

// ==== tb.sv ====
// self-checking bench of the serial slave engine
`timescale 1ns/1ps
`include "ssm_regs.vh"
module tb;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [1:0] sel_mode = 2'h0;
  reg reboot_busy = 1'b0;
  reg nvm_busy = 1'b0;
  reg [7:0] mem_rdata = 8'h00;
  reg [7:0] wa = 8'h00;
  reg [7:0] wd = 8'h00;
  wire scl, sda, sda_o, sda_oe, mem_rd_req, mem_wr_req, reboot_req, fault_store_req;
  wire [7:0] mem_addr, mem_wdata;
  wire [1:0] mem_page;
  // select pin tied low, high, to the clock or to the data line
  wire sel_pin = sel_mode == 2'h2 ? scl : (sel_mode == 2'h3 ? sda : sel_mode[0]);
  integer err_total = 0, samples_checked = 0, wn = 0, nb = 0, nf = 0, k;
  localparam [7:0] DA = {`SSM_DEV_ID, `SSM_SEL_LOW, 2'h0};
  localparam [7:0] PA = 8'h30;
  always #5 clk = ~clk;
  ssm_master_model m (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  ssm_i2c_slave uut (.clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .bus_address_select_pin(sel_pin), .reboot_busy(reboot_busy),
    .nvm_busy(nvm_busy), .mem_rd_req(mem_rd_req), .mem_wr_req(mem_wr_req),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_page(mem_page), .mem_rdata(mem_rdata),
    .reboot_req(reboot_req), .fault_store_req(fault_store_req));
  // memory and command-pulse model
  always @(posedge clk) begin
    mem_rdata <= mem_addr ^ 8'h3c;
    if (mem_wr_req) begin
      wn <= wn + 1;
      wa <= mem_addr;
      wd <= mem_wdata;
    end
    if (reboot_req) nb <= nb + 1;
    if (fault_store_req) nf <= nf + 1;
  end
  task chk(input [7:0] got, input [7:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task results;
    begin
      if (err_total == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  task wb(input [7:0] b, input e);
    reg a;
    begin
      m.wbyte(b, a);
      chk({7'h00, a}, {7'h00, e});
    end
  endtask
  task rb(input nak, input [7:0] exp);
    reg [7:0] d;
    begin
      m.rbyte(nak, d);
      chk(d, exp);
    end
  endtask
  task send(input [7:0] c, input e);
    begin
      m.start;
      wb(DA, 1'b1);
      wb(c, e);
      m.stop;
    end
  endtask
  task rx(input [7:0] exp);
    begin
      m.start;
      wb(DA | 8'h01, 1'b1);
      rb(1'b1, exp);
      m.stop;
    end
  endtask
  // address decode, send byte, receive byte, refused pointer
  task t_addr;
    reg r;
    begin
      m.start;
      wb({`SSM_DEV_ID, `SSM_SEL_HIGH, 2'h0}, 1'b0);
      m.stop;
      m.start;
      wb(DA | 8'h02, 1'b1);
      wb(8'h10, 1'b1);
      m.stop;
      rx(8'h10 ^ 8'h3c);
      rx(8'h11 ^ 8'h3c);
      send(8'h80, 1'b0);
      rx(8'h12 ^ 8'h3c);
      // stop after seven command bits, before the acknowledge
      m.start;
      wb(DA, 1'b1);
      for (k = 7; k > 0; k = k - 1) begin
        m.bit_x(PA[k], r);
      end
      m.stop;
      rx(8'h13 ^ 8'h3c);
    end
  endtask
  // byte write, valid and refused address
  task t_wr;
    begin
      m.start;
      wb(DA, 1'b1);
      wb(8'h20, 1'b1);
      wb(8'h5a, 1'b1);
      m.stop;
      chk(wa, 8'h20);
      chk(wd, 8'h5a);
      m.start;
      wb(DA, 1'b1);
      wb(8'h7e, 1'b0);
      m.stop;
      chk(wn[7:0], 8'h01);
    end
  endtask
  // busy refusal and retry
  task t_busy;
    begin
      nvm_busy <= 1'b1;
      send(`SSM_CMD_BLK_WR, 1'b0);
      nvm_busy <= 1'b0;
      reboot_busy <= 1'b1;
      send(8'h10, 1'b0);
      reboot_busy <= 1'b0;
      send(`SSM_CMD_BLK_WR, 1'b1);
    end
  endtask
  // page codes, reboot, fault store
  task t_cmd;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        send(`SSM_CMD_EXT_ON + k[7:0], 1'b1);
        chk({6'h00, mem_page}, {6'h00, k[0] ? `SSM_PAGE_DEF :
          (k[1] ? `SSM_PAGE_NVM : `SSM_PAGE_EXT)});
      end
      send(`SSM_CMD_NVM_ON, 1'b1);
      send(`SSM_CMD_REBOOT, 1'b1);
      send(`SSM_CMD_FAULT, 1'b1);
      chk(nb[7:0], 8'h01);
      chk(nf[7:0], 8'h01);
      chk({6'h00, mem_page}, {6'h00, `SSM_PAGE_DEF});
    end
  endtask
  // block write saturating at the last register, bad count
  task t_bw;
    begin
      send(8'h7c, 1'b1);
      m.start;
      wb(DA, 1'b1);
      wb(`SSM_CMD_BLK_WR, 1'b1);
      wb(8'h03, 1'b1);
      wb(8'h11, 1'b1);
      wb(8'h22, 1'b1);
      wb(8'h33, 1'b1);
      m.stop;
      chk(wn[7:0], 8'h04);
      chk(wa, 8'h7d);
      chk(wd, 8'h33);
      m.start;
      wb(DA, 1'b1);
      wb(`SSM_CMD_BLK_WR, 1'b1);
      wb(8'h00, 1'b0);
      m.stop;
    end
  endtask
  // block read in nonvolatile page, saturating at the top
  task t_br;
    reg [7:0] d;
    begin
      send(`SSM_CMD_NVM_ON, 1'b1);
      send(8'hfe, 1'b1);
      m.start;
      wb(DA | 8'h01, 1'b1);
      m.rbyte(1'b1, d);
      m.stop;
      send(8'hfe, 1'b1);
      m.start;
      wb(DA, 1'b1);
      wb(`SSM_CMD_BLK_RD, 1'b1);
      m.start;
      wb(DA | 8'h01, 1'b1);
      rb(1'b0, 8'h10);
      rb(1'b0, 8'hfe ^ 8'h3c);
      rb(1'b0, 8'hff ^ 8'h3c);
      rb(1'b1, 8'hff ^ 8'h3c);
      m.stop;
      send(`SSM_CMD_NVM_OFF, 1'b1);
    end
  endtask
  // every other select-pin state, each after its own reset
  task t_sel;
    begin
      for (k = 1; k < 4; k = k + 1) begin
        sel_mode <= k[1:0];
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        m.start;
        wb({`SSM_DEV_ID, k[1:0] ^ 2'h1, 2'h0}, 1'b0);
        m.stop;
        m.start;
        wb({`SSM_DEV_ID, k[1:0], 2'h0}, 1'b1);
        m.stop;
      end
    end
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_addr;
    t_wr;
    t_busy;
    t_cmd;
    t_bw;
    t_br;
    t_sel;
    results;
  end
  // watchdog
  initial begin
    #1000000;
    err_total = err_total + 1;
    results;
  end
endmodule
